// >>> pkg/mvs_defs.vh
`ifndef MVS_DEFS_VH
`define MVS_DEFS_VH

// Register byte offsets
`define MVS_REG_CTRL      6'h00
`define MVS_REG_SCALE_LO  6'h04
`define MVS_REG_SCALE_HI  6'h08
`define MVS_REG_PEAK_MIN  6'h0c
`define MVS_REG_HOLD_TIME 6'h10
`define MVS_REG_RANGE_EXT 6'h14
`define MVS_REG_STATUS    6'h18
`define MVS_REG_VALUE     6'h1c
`define MVS_REG_PEAK      6'h20
`define MVS_REG_IRQ_STAT  6'h24
`define MVS_REG_IRQ_CLR   6'h28
`define MVS_REG_IRQ_EN    6'h2c

// CTRL fields
`define MVS_CTRL_RANGE     0
`define MVS_CTRL_CHAR_LO   1
`define MVS_CTRL_CHAR_HI   2
`define MVS_CTRL_PEAK_MODE 3
`define MVS_CTRL_DISP_SRC  4
`define MVS_CTRL_W         5

// Characteristic codes
`define MVS_CHAR_LIN  2'h0
`define MVS_CHAR_SQR  2'h1
`define MVS_CHAR_ROOT 2'h2

// RANGE_EXT fields, tenths of a percent
`define MVS_EXT_LO_MSB 9
`define MVS_EXT_HI_LSB 16
`define MVS_EXT_HI_MSB 23

// Interrupt bits
`define MVS_IRQ_DONE   0
`define MVS_IRQ_PEAK   1
`define MVS_IRQ_OVF    2
`define MVS_IRQ_RANGE  3
`define MVS_IRQ_EXPIRE 4
`define MVS_IRQ_W      5

// Reset values
`define MVS_RST_CTRL      5'h00
`define MVS_RST_SCALE_LO  16'h0000
`define MVS_RST_SCALE_HI  16'h03e8
`define MVS_RST_PEAK_MIN  16'h000a
`define MVS_RST_HOLD_TIME 8'h00
`define MVS_RST_EXT_LO    10'h000
`define MVS_RST_EXT_HI    8'h00

// Input scaling, sample unit is 1 uA
`define MVS_OFFS_4MA   18'h00fa0
`define MVS_SPAN_16MA  16'h3e80
`define MVS_SPAN_20MA  16'h4e20
`define MVS_TOP_20MA   18'h04e20
`define MVS_LO_EXT_MUL 18'h00004
`define MVS_HI_EXT_MUL 18'h00014
`define MVS_FRAC_BITS  14
`define MVS_DIV_STEPS  5'h1e
`define MVS_ROUND_HALF 35'h000002000

// Displayable window
`define MVS_DISP_MIN 21'h1ffc19
`define MVS_DISP_MAX 21'h00270f

// Timing
`define MVS_CLK_HZ   25000000
`define MVS_TICK_MS  100
`define MVS_HOLD_MAX 8'hc7

`endif

// >>> rtl/mvs_isqrt.v
`timescale 1ns/100ps
module mvs_isqrt (
  input wire clk_i,           // System clock
  input wire rst_i,           // Async reset, active high
  input wire start_i,         // Start pulse
  input wire [31:0] radicand_i, // Value to root
  output reg done_o,          // Root ready pulse
  output reg [15:0] root_o    // Integer root
);
  reg [31:0] rad;
  reg [17:0] rem;
  reg [4:0] cnt;
  reg busy;
  wire [17:0] rem_sh = {rem[15:0], rad[31:30]};
  wire [17:0] trial = {root_o, 2'h1};

  // Digit by digit, two radicand bits per cycle
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rad <= 32'h0;
      rem <= 18'h0;
      cnt <= 5'h0;
      busy <= 1'b0;
      done_o <= 1'b0;
      root_o <= 16'h0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        rad <= radicand_i;
        rem <= 18'h0;
        root_o <= 16'h0;
        cnt <= 5'h10;
        busy <= 1'b1;
      end else if (busy) begin
        rad <= {rad[29:0], 2'h0};
        if (rem_sh >= trial) begin
          rem <= rem_sh - trial;
          root_o <= {root_o[14:0], 1'b1};
        end else begin
          rem <= rem_sh;
          root_o <= {root_o[14:0], 1'b0};
        end
        cnt <= cnt - 5'h1;
        if (cnt == 5'h1) begin
          busy <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule

// >>> rtl/mvs_top.v
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "mvs_defs.vh"
// Notes on behaviour
// - 4-20 mA: subtract 4 mA, divide by 16
// - 0-20 mA: divide by 20 mA, no offset
// - No clamping of normalized result outside 0..1
// - Linear: n times span plus low value
// - Span is signed; low may exceed high
// - Square: n squared times span plus low
// - Root: sqrt(n) times span plus low
// - Root with negative n shows low value
// - Rising mode: rise then fall by minimum change
// - Falling mode: fall then rise by minimum change
// - Hold lasts at most hold time, 0.1 s steps
// - Held source, zero time: hold until cancel key
// - Live source, zero time: no holding
// - Source select: live value or captured value
// - Value outside -999..9999 shows overflow
// - Input outside permissible range shows under/over
module mvs_top #(
  parameter TICK_CYCLES = `MVS_CLK_HZ / 1000 * `MVS_TICK_MS
) (
  input wire CLK_SYS_I,             // 25 MHz system clock
  input wire SYS_RST_I,             // Async reset, active high
  input wire [5:0] ADDRESS_I,       // Avalon byte address
  input wire READ_I,                // Avalon read
  input wire WRITE_I,               // Avalon write
  input wire [31:0] WRITEDATA_I,    // Avalon write data
  output reg [31:0] READDATA_O,     // Avalon read data
  output wire WAITREQUEST_O,        // Avalon wait request
  input wire signed [15:0] SAMPLE_I, // Measured input, uA
  input wire SAMPLE_VALID_I,        // Sample strobe
  output wire SAMPLE_READY_O,       // Datapath idle
  input wire CANCEL_KEY_I,          // Cancel key pin, active high
  output reg signed [15:0] DISP_VALUE_O, // Value to display
  output reg DISP_OVERFLOW_O,       // Overflow indication
  output reg DISP_UNDER_O,          // Under-range indication
  output reg DISP_OVER_O,           // Over-range indication
  output reg DISP_HELD_O,           // Display shows held value
  output wire IRQ_O                 // Level interrupt
);
  localparam S_IDLE = 3'h0;
  localparam S_DIV = 3'h1;
  localparam S_CHAR = 3'h2;
  localparam S_ROOT = 3'h3;
  localparam S_SCALE = 3'h4;

  reg [`MVS_CTRL_W-1:0] ctrl;
  reg signed [15:0] scale_low_value;
  reg signed [15:0] scale_high_value;
  reg [15:0] peak_min_change;
  reg [7:0] peak_hold_duration;
  reg [9:0] lower_range_extension;
  reg [7:0] upper_range_extension;
  reg [`MVS_IRQ_W-1:0] irq_stat;
  reg [`MVS_IRQ_W-1:0] irq_en;
  reg ack;

  wire range_0_20 = ctrl[`MVS_CTRL_RANGE];
  wire [1:0] char_sel = ctrl[`MVS_CTRL_CHAR_HI:`MVS_CTRL_CHAR_LO];
  wire falling_mode = ctrl[`MVS_CTRL_PEAK_MODE];
  wire held_src = ctrl[`MVS_CTRL_DISP_SRC];

  // Bus: one wait state, answer on the second edge
  wire req = READ_I | WRITE_I;
  assign WAITREQUEST_O = req & ~ack;
  wire wr_en = WRITE_I & ack;

  reg [2:0] state;
  reg [2:0] next_state;
  reg signed [15:0] samp;
  reg neg;
  reg [29:0] dnum;
  reg [15:0] drem;
  reg [29:0] quo;
  reg [4:0] dcnt;
  reg signed [17:0] fval;
  reg sqrt_start;
  wire sqrt_done;
  wire [15:0] sqrt_root;

  reg signed [15:0] live_val;
  reg live_ovf;
  reg live_under;
  reg live_over;
  reg signed [15:0] trk;
  reg trk_valid;
  reg signed [15:0] held_val;
  reg holding;
  reg [7:0] hold_cnt;
  reg [22:0] tick_div;
  reg tick;
  reg k1, k2, k3, key_lvl, key_prev;
  reg ev_done, ev_peak, ev_ovf, ev_range, ev_expire;

  assign SAMPLE_READY_O = (state == S_IDLE);

  // Permissible range and normalization constants
  wire signed [17:0] samp_x = {{2{SAMPLE_I[15]}}, SAMPLE_I};
  wire signed [17:0] base = range_0_20 ? 18'h0 : `MVS_OFFS_4MA;
  wire [15:0] span = range_0_20 ? `MVS_SPAN_20MA : `MVS_SPAN_16MA;
  wire [17:0] lo_cut = lower_range_extension * `MVS_LO_EXT_MUL;
  wire [17:0] hi_add = upper_range_extension * `MVS_HI_EXT_MUL;
  wire signed [17:0] lo_border = range_0_20 ? 18'h0 : (`MVS_OFFS_4MA - lo_cut);
  wire signed [17:0] hi_border = `MVS_TOP_20MA + hi_add;
  wire signed [17:0] offs = samp_x - base;
  wire [17:0] offs_mag = offs[17] ? (18'h0 - offs) : offs;

  // Restoring division of the offset by the span
  wire [16:0] rem_sh = {drem, dnum[29]};
  wire rem_ge = rem_sh >= {1'b0, span};
  wire [16:0] rem_sub = rem_sh - {1'b0, span};

  wire signed [17:0] quo_s = {1'b0, quo[16:0]};
  wire signed [17:0] nrm = neg ? (18'h0 - quo_s) : quo_s;
  wire signed [35:0] sqr = nrm * nrm;

  // Final scaling, signed span
  wire signed [16:0] span_c = {scale_high_value[15], scale_high_value}
    - {scale_low_value[15], scale_low_value};
  wire signed [34:0] prod = fval * span_c;
  wire signed [34:0] prod_r = prod + `MVS_ROUND_HALF;
  wire signed [20:0] w_full = $signed(prod_r[34:14])
    + $signed({{5{scale_low_value[15]}}, scale_low_value});
  wire w_ovf = (w_full < $signed(`MVS_DISP_MIN)) | (w_full > $signed(`MVS_DISP_MAX));
  wire in_over = $signed({{2{samp[15]}}, samp}) > hi_border;
  wire in_lo = $signed({{2{samp[15]}}, samp}) < lo_border;

  mvs_isqrt u_isqrt (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .start_i(sqrt_start),
    .radicand_i({quo[17:0], 14'h0}),
    .done_o(sqrt_done),
    .root_o(sqrt_root)
  );

  always @* begin
    next_state = state;
    case (state)
      S_IDLE: if (SAMPLE_VALID_I) next_state = S_DIV;
      S_DIV: if (dcnt == 5'h1) next_state = S_CHAR;
      S_CHAR: next_state = (char_sel == `MVS_CHAR_ROOT && !neg) ? S_ROOT : S_SCALE;
      S_ROOT: if (sqrt_done) next_state = S_SCALE;
      S_SCALE: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // Datapath sequencing
  always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state <= S_IDLE;
      samp <= 16'h0;
      neg <= 1'b0;
      dnum <= 30'h0;
      drem <= 16'h0;
      quo <= 30'h0;
      dcnt <= 5'h0;
      fval <= 18'h0;
      sqrt_start <= 1'b0;
      live_val <= 16'h0;
      live_ovf <= 1'b0;
      live_under <= 1'b0;
      live_over <= 1'b0;
      ev_done <= 1'b0;
      ev_ovf <= 1'b0;
      ev_range <= 1'b0;
    end else begin
      state <= next_state;
      sqrt_start <= 1'b0;
      ev_done <= 1'b0;
      ev_ovf <= 1'b0;
      ev_range <= 1'b0;
      case (state)
        S_IDLE: begin
          if (SAMPLE_VALID_I) begin
            samp <= SAMPLE_I;
            neg <= offs[17];
            dnum <= {offs_mag[15:0], 14'h0};
            drem <= 16'h0;
            quo <= 30'h0;
            dcnt <= `MVS_DIV_STEPS;
          end
        end
        S_DIV: begin
          dnum <= {dnum[28:0], 1'b0};
          drem <= rem_ge ? rem_sub[15:0] : rem_sh[15:0];
          quo <= {quo[28:0], rem_ge};
          dcnt <= dcnt - 5'h1;
        end
        S_CHAR: begin
          case (char_sel)
            `MVS_CHAR_SQR: fval <= sqr[31:14];
            `MVS_CHAR_ROOT: begin
              fval <= 18'h0;
              sqrt_start <= !neg;
            end
            default: fval <= nrm;
          endcase
        end
        S_ROOT: if (sqrt_done) fval <= {2'h0, sqrt_root};
        S_SCALE: begin
          live_under <= in_lo;
          live_over <= in_over;
          live_ovf <= w_ovf & ~in_lo & ~in_over;
          live_val <= (w_ovf | in_lo | in_over) ? 16'h0 : w_full[15:0];
          ev_done <= 1'b1;
          ev_ovf <= w_ovf & ~in_lo & ~in_over;
          ev_range <= in_lo | in_over;
        end
        default: ;
      endcase
    end
  end

  // Cancel key: three stages, accepted when the last two agree
  always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      k1 <= 1'b0;
      k2 <= 1'b0;
      k3 <= 1'b0;
      key_lvl <= 1'b0;
      key_prev <= 1'b0;
    end else begin
      k1 <= CANCEL_KEY_I;
      k2 <= k1;
      k3 <= k2;
      if (k2 == k3) key_lvl <= k3;
      key_prev <= key_lvl;
    end
  end
  wire key_press = key_lvl & ~key_prev;

  // Peak and drop detection on each fresh in-range result
  wire new_ok = ev_done & ~live_under & ~live_over & ~live_ovf;
  wire [16:0] fall_by = {trk[15], trk} - {live_val[15], live_val};
  wire [16:0] rise_by = {live_val[15], live_val} - {trk[15], trk};
  wire [16:0] min_x = {1'b0, peak_min_change};
  wire peak_hit = !falling_mode && live_val < trk
    && $signed(fall_by) >= $signed(min_x);
  wire drop_hit = falling_mode && live_val > trk
    && $signed(rise_by) >= $signed(min_x);
  wire no_hold = (peak_hold_duration == 8'h0) && !held_src;
  wire capture = new_ok && trk_valid && (peak_hit || drop_hit) && !no_hold;
  wire expire = holding && peak_hold_duration != 8'h0
    && hold_cnt >= peak_hold_duration;

  // 0.1 s tick, restarted on capture so a hold never ends a tick early
  always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      tick_div <= 23'h0;
      tick <= 1'b0;
    end else if (capture) begin
      tick_div <= 23'h0;
      tick <= 1'b0;
    end else if (tick_div == TICK_CYCLES[22:0] - 23'h1) begin
      tick_div <= 23'h0;
      tick <= 1'b1;
    end else begin
      tick_div <= tick_div + 23'h1;
      tick <= 1'b0;
    end
  end

  always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      trk <= 16'h0;
      trk_valid <= 1'b0;
      held_val <= 16'h0;
      holding <= 1'b0;
      hold_cnt <= 8'h0;
      ev_peak <= 1'b0;
      ev_expire <= 1'b0;
    end else begin
      ev_peak <= capture;
      ev_expire <= 1'b0;
      if (new_ok) begin
        if (!trk_valid || peak_hit || drop_hit) begin
          trk <= live_val;
        end else if (falling_mode ? (live_val < trk) : (live_val > trk)) begin
          trk <= live_val;
        end
        trk_valid <= 1'b1;
      end
      if (capture) begin
        held_val <= trk;
        holding <= 1'b1;
        hold_cnt <= 8'h0;
      end else if (expire) begin
        holding <= 1'b0;
        ev_expire <= 1'b1;
      end else if (holding && key_press) begin
        holding <= 1'b0;
        ev_expire <= 1'b1;
      end else if (holding && no_hold) begin
        holding <= 1'b0;
      end else if (holding && tick && hold_cnt != `MVS_HOLD_MAX) begin
        hold_cnt <= hold_cnt + 8'h1;
      end
    end
  end

  // Display source selection
  wire show_held = held_src && holding;
  always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      DISP_VALUE_O <= 16'h0;
      DISP_OVERFLOW_O <= 1'b0;
      DISP_UNDER_O <= 1'b0;
      DISP_OVER_O <= 1'b0;
      DISP_HELD_O <= 1'b0;
    end else begin
      DISP_VALUE_O <= show_held ? held_val : live_val;
      DISP_OVERFLOW_O <= ~show_held & live_ovf;
      DISP_UNDER_O <= ~show_held & live_under;
      DISP_OVER_O <= ~show_held & live_over;
      DISP_HELD_O <= show_held;
    end
  end

  // Register file
  wire [`MVS_IRQ_W-1:0] irq_set = {ev_expire, ev_range, ev_ovf, ev_peak, ev_done};
  wire clr_hit = wr_en && ADDRESS_I == `MVS_REG_IRQ_CLR;
  wire [`MVS_IRQ_W-1:0] irq_clr = clr_hit ? WRITEDATA_I[`MVS_IRQ_W-1:0] : 5'h0;
  assign IRQ_O = |(irq_stat & irq_en);

  always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ack <= 1'b0;
      READDATA_O <= 32'h0;
      ctrl <= `MVS_RST_CTRL;
      scale_low_value <= `MVS_RST_SCALE_LO;
      scale_high_value <= `MVS_RST_SCALE_HI;
      peak_min_change <= `MVS_RST_PEAK_MIN;
      peak_hold_duration <= `MVS_RST_HOLD_TIME;
      lower_range_extension <= `MVS_RST_EXT_LO;
      upper_range_extension <= `MVS_RST_EXT_HI;
      irq_stat <= 5'h0;
      irq_en <= 5'h0;
    end else begin
      ack <= req & ~ack;
      // Set wins over a clear in the same cycle
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      if (wr_en) begin
        case (ADDRESS_I)
          `MVS_REG_CTRL: ctrl <= WRITEDATA_I[`MVS_CTRL_W-1:0];
          `MVS_REG_SCALE_LO: scale_low_value <= WRITEDATA_I[15:0];
          `MVS_REG_SCALE_HI: scale_high_value <= WRITEDATA_I[15:0];
          `MVS_REG_PEAK_MIN: peak_min_change <= WRITEDATA_I[15:0];
          // Out-of-range hold times saturate at 19.9 s
          `MVS_REG_HOLD_TIME: peak_hold_duration <= (WRITEDATA_I[7:0] > `MVS_HOLD_MAX)
            ? `MVS_HOLD_MAX : WRITEDATA_I[7:0];
          `MVS_REG_RANGE_EXT: begin
            lower_range_extension <= WRITEDATA_I[`MVS_EXT_LO_MSB:0];
            upper_range_extension <= WRITEDATA_I[`MVS_EXT_HI_MSB:`MVS_EXT_HI_LSB];
          end
          `MVS_REG_IRQ_EN: irq_en <= WRITEDATA_I[`MVS_IRQ_W-1:0];
          default: ;
        endcase
      end
      if (READ_I & ~ack) begin
        case (ADDRESS_I)
          `MVS_REG_CTRL: READDATA_O <= {27'h0, ctrl};
          `MVS_REG_SCALE_LO: READDATA_O <= {{16{scale_low_value[15]}}, scale_low_value};
          `MVS_REG_SCALE_HI: READDATA_O <= {{16{scale_high_value[15]}}, scale_high_value};
          `MVS_REG_PEAK_MIN: READDATA_O <= {16'h0, peak_min_change};
          `MVS_REG_HOLD_TIME: READDATA_O <= {24'h0, peak_hold_duration};
          `MVS_REG_RANGE_EXT: READDATA_O <= {8'h0, upper_range_extension,
            6'h0, lower_range_extension};
          `MVS_REG_STATUS: READDATA_O <= {26'h0, state != S_IDLE, holding,
            live_over, live_under, live_ovf, trk_valid};
          `MVS_REG_VALUE: READDATA_O <= {{16{live_val[15]}}, live_val};
          `MVS_REG_PEAK: READDATA_O <= {{16{held_val[15]}}, held_val};
          `MVS_REG_IRQ_STAT: READDATA_O <= {27'h0, irq_stat};
          `MVS_REG_IRQ_EN: READDATA_O <= {27'h0, irq_en};
          default: READDATA_O <= 32'h0;
        endcase
      end
    end
  end
endmodule

// >>> tb/meter_value_scaling_peak_hold_tb_top.sv
`timescale 1ns/100ps
`include "mvs_defs.vh"
module meter_value_scaling_peak_hold_tb_top;
  localparam int TICKS = 20;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [5:0] addr = 6'h00;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg go = 1'b0;
  reg [15:0] val = 16'h0;
  reg press = 1'b0;
  reg [31:0] rv;
  wire [31:0] rdata;
  wire [15:0] sample, disp;
  wire wait_req, ready, valid, cancel, busy, ovf, under, over, held, irq;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  mvs_top #(.TICK_CYCLES(TICKS)) mvs_top_inst (.CLK_SYS_I(clk), .SYS_RST_I(rst),
    .ADDRESS_I(addr), .READ_I(rd), .WRITE_I(wr), .WRITEDATA_I(wdata), .READDATA_O(rdata),
    .WAITREQUEST_O(wait_req), .SAMPLE_I(sample), .SAMPLE_VALID_I(valid),
    .SAMPLE_READY_O(ready), .CANCEL_KEY_I(cancel), .DISP_VALUE_O(disp),
    .DISP_OVERFLOW_O(ovf), .DISP_UNDER_O(under), .DISP_OVER_O(over),
    .DISP_HELD_O(held), .IRQ_O(irq));
  mvs_frontend_model mvs_frontend_model_inst (.clk_i(clk), .rst_i(rst), .go_i(go),
    .value_i(val), .press_i(press), .ready_i(ready), .sample_o(sample), .valid_o(valid),
    .cancel_o(cancel), .busy_o(busy));
  task final_report;
    if (errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input w, input [5:0] a, input [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do @(posedge clk); while (wait_req !== 1'b0);
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task smp(input [15:0] s);
    go <= 1'b1;
    val <= s;
    @(posedge clk);
    go <= 1'b0;
    // Guard cycles let the strobe reach the model before idle counts
    for (int i = 0; i < 200 && (i < 3 || busy !== 1'b0 || ready !== 1'b1); i++)
      @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  task key;
    press <= 1'b1;
    repeat (6) @(posedge clk);
    press <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task run(input [4:0] c, input [15:0] lo, input [15:0] hi, input [15:0] s,
           input [15:0] e, input [2:0] f);
    bus(1, `MVS_REG_CTRL, {27'h0, c});
    bus(1, `MVS_REG_SCALE_LO, {16'h0, lo});
    bus(1, `MVS_REG_SCALE_HI, {16'h0, hi});
    smp(s);
    chk({29'h0, ovf, under, over}, {29'h0, f});
    if (f == 3'b000)
      chk({16'h0, disp}, {16'h0, e});
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus(0, `MVS_REG_SCALE_HI, 0);
    chk(rv, 32'h0000_03e8);
    bus(0, `MVS_REG_PEAK_MIN, 0);
    chk(rv, 32'h0000_000a);
    bus(1, 6'h30, 32'hffff_ffff);
    bus(0, 6'h30, 0);
    chk(rv, 32'h0);
    bus(1, `MVS_REG_VALUE, 32'h0000_0123);
    bus(0, `MVS_REG_VALUE, 0);
    chk(rv, 32'h0);
    bus(1, `MVS_REG_IRQ_EN, 32'h0000_001f);
    run(0, -300, 1300, 12000, 500, 0);
    @(posedge clk);
    chk({31'h0, irq}, 1);
    bus(1, `MVS_REG_IRQ_CLR, 32'h0000_001f);
    @(posedge clk);
    chk({31'h0, irq}, 0);
    bus(1, `MVS_REG_IRQ_EN, 32'h0);
    run(1, -300, 1300, 10000, 500, 0);
    chk({31'h0, irq}, 0);
    bus(0, `MVS_REG_IRQ_STAT, 0);
    chk({31'h0, rv[0]}, 1);
    bus(1, `MVS_REG_RANGE_EXT, 32'h0000_00fa);
    run(0, -300, 1300, 3000, -400, 0);
    run(0, -300, 1300, 2999, 0, 3'b010);
    bus(1, `MVS_REG_RANGE_EXT, 32'h000a_0000);
    run(0, -300, 1300, 20200, 1320, 0);
    run(0, -300, 1300, 20201, 0, 3'b001);
    run(0, -300, 1300, 3999, 0, 3'b010);
    run(0, 1300, -300, 16000, 100, 0);
    run(2, -300, 1300, 12000, 100, 0);
    run(4, -300, 1300, 8000, 500, 0);
    bus(1, `MVS_REG_RANGE_EXT, 32'h0000_00fa);
    run(4, -300, 1300, 3000, -300, 0);
    run(0, -999, 1000, 4000, -999, 0);
    run(0, -1000, 1000, 4000, 0, 3'b100);
    run(0, 0, 16000, 20000, 0, 3'b100);
    run(0, -300, 1300, 12000, 500, 0);
    bus(1, `MVS_REG_CTRL, 32'h0000_0010);
    smp(16000);
    smp(12000);
    chk({31'h0, held}, 1);
    chk({16'h0, disp}, 32'h0000_0384);
    bus(0, `MVS_REG_PEAK, 0);
    chk(rv, 32'h0000_0384);
    bus(0, `MVS_REG_STATUS, 0);
    chk(rv, 32'h0000_0011);
    repeat (100) @(posedge clk);
    chk({31'h0, held}, 1);
    key;
    chk({31'h0, held}, 0);
    bus(1, `MVS_REG_CTRL, 32'h0000_0018);
    smp(8000);
    smp(12000);
    chk({31'h0, held}, 1);
    chk({16'h0, disp}, 32'h0000_0064);
    key;
    bus(1, `MVS_REG_HOLD_TIME, 32'h1);
    bus(1, `MVS_REG_CTRL, 32'h0000_0010);
    smp(16000);
    smp(12000);
    chk({31'h0, held}, 1);
    repeat (TICKS + 10) @(posedge clk);
    chk({31'h0, held}, 0);
    bus(1, `MVS_REG_HOLD_TIME, 32'h0);
    bus(1, `MVS_REG_CTRL, 32'h0);
    smp(16000);
    smp(12000);
    chk({31'h0, held}, 0);
    chk({16'h0, disp}, 32'h0000_01f4);
    final_report;
  end
  // Whole run needs under two thousand cycles; ceiling leaves wide margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors = errors + 1;
      final_report;
    end
  end
endmodule

// >>> tb/mvs_frontend_model.sv
`timescale 1ns/100ps
module mvs_frontend_model (
  input wire clk_i, // Clock
  input wire rst_i, // Reset
  input wire go_i, // Send one sample
  input wire [15:0] value_i, // Sample value
  input wire press_i, // Operator key
  input wire ready_i, // Datapath idle
  output reg [15:0] sample_o, // Sample bus
  output reg valid_o, // Sample strobe
  output reg cancel_o, // Key pin
  output wire busy_o // Sample pending
);
  reg pend;
  assign busy_o = pend | valid_o;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend <= 1'b0;
      valid_o <= 1'b0;
      sample_o <= 16'h0000;
      cancel_o <= 1'b0;
    end else begin
      cancel_o <= press_i;
      if (go_i)
        pend <= 1'b1;
      if (valid_o && ready_i) begin
        valid_o <= 1'b0;
        // Scrambled so a stale sample is never read as valid
        sample_o <= ~sample_o;
      end else if (pend && !valid_o) begin
        valid_o <= 1'b1;
        sample_o <= value_i;
        pend <= 1'b0;
      end
    end
  end
endmodule

// >>> tb/mvs_properties.sv
`timescale 1ns/100ps
`include "mvs_defs.vh"
module mvs_properties (
  input wire CLK_SYS_I, // Clock
  input wire SYS_RST_I, // Reset
  input wire [5:0] ADDRESS_I, // Address
  input wire READ_I, // Read
  input wire WRITE_I, // Write
  input wire [31:0] WRITEDATA_I, // Write data
  input wire [31:0] READDATA_O, // Read data
  input wire WAITREQUEST_O, // Wait request
  input wire SAMPLE_VALID_I, // Sample strobe
  input wire SAMPLE_READY_O, // Datapath idle
  input wire DISP_OVERFLOW_O, // Overflow
  input wire DISP_UNDER_O, // Under range
  input wire DISP_OVER_O, // Over range
  input wire DISP_HELD_O, // Held shown
  input wire IRQ_O // Interrupt
);
  wire bus_req;
  assign bus_req = READ_I || WRITE_I;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_taken;
    SAMPLE_VALID_I && SAMPLE_READY_O;
  endsequence
  sequence s_busy;
    !SAMPLE_READY_O [*8];
  endsequence
  one_wait_a: assert property (bus_req && WAITREQUEST_O |=> !WAITREQUEST_O)
    else $error("bus answer later than one wait state");
  first_wait_a: assert property (bus_req && !$past(bus_req) |-> WAITREQUEST_O)
    else $error("new request not stalled");
  idle_wait_a: assert property (!bus_req |-> !WAITREQUEST_O)
    else $error("wait request while idle");
  rdata_hold_a: assert property (!READ_I |=> $stable(READDATA_O))
    else $error("read data moved without a read");
  take_busy_a: assert property (s_taken |=> s_busy)
    else $error("datapath idle right after taking a sample");
  result_bound_a: assert property (s_taken |-> ##[2:80] SAMPLE_READY_O)
    else $error("datapath result late");
  flag_onehot_a: assert property ($onehot0({DISP_OVERFLOW_O, DISP_UNDER_O, DISP_OVER_O}))
    else $error("several indications at once");
  held_clean_a: assert property (DISP_HELD_O |-> !(DISP_OVERFLOW_O || DISP_UNDER_O))
    else $error("indication shown with held value");
  irq_mask_a: assert property (WRITE_I && !WAITREQUEST_O && ADDRESS_I == `MVS_REG_IRQ_EN
    && WRITEDATA_I[4:0] == 5'h00 |=> !IRQ_O)
    else $error("interrupt high with all sources masked");
endmodule
bind mvs_top mvs_properties mvs_properties_inst (.CLK_SYS_I(CLK_SYS_I),
  .SYS_RST_I(SYS_RST_I), .ADDRESS_I(ADDRESS_I), .READ_I(READ_I), .WRITE_I(WRITE_I),
  .WRITEDATA_I(WRITEDATA_I), .READDATA_O(READDATA_O), .WAITREQUEST_O(WAITREQUEST_O),
  .SAMPLE_VALID_I(SAMPLE_VALID_I), .SAMPLE_READY_O(SAMPLE_READY_O),
  .DISP_OVERFLOW_O(DISP_OVERFLOW_O), .DISP_UNDER_O(DISP_UNDER_O),
  .DISP_OVER_O(DISP_OVER_O), .DISP_HELD_O(DISP_HELD_O), .IRQ_O(IRQ_O));
